// *** mute_seq_pkg.sv ***
// shared constants for the channel fault and mute sequencer
package mute_seq_pkg;
    localparam int NUM_CH = 4;
    localparam int RAMP_W = 10;
    localparam logic [RAMP_W-1:0] RAMP_FULL = 10'h3FF;
    // thresholds as fractions of the bypass reference (full scale)
    localparam logic [RAMP_W-1:0] LVL_TENTH = 10'h066;
    localparam logic [RAMP_W-1:0] LVL_THIRD = 10'h155;
    localparam logic [RAMP_W-1:0] LVL_TWO_THIRD = 10'h2AA;
    localparam logic [RAMP_W-1:0] LVL_NINE_TENTH = 10'h399;
    localparam logic [RAMP_W-1:0] RAMP_RST = 10'h000;
    localparam logic [7:0] GAIN_MAX = 8'hFF;
    // ramp step period standing in for the capacitor time constant
    localparam real STEP_NS = 1000.0;
    localparam real CLK_NS = 50.0;
    localparam int STEP_CYC = int'(STEP_NS / CLK_NS);
    localparam logic [1:0] MODE_FLOAT = 2'h0;
    localparam logic [1:0] MODE_MUTE = 2'h1;
    localparam logic [1:0] MODE_PLAY = 2'h2;
    typedef enum logic [1:0] {
        ST_FLOAT = 2'b00,
        ST_MUTE = 2'b01,
        ST_PLAY = 2'b11,
        ST_DIAG = 2'b10
    } ch_state_e;
endpackage

// *** ramp_if.sv ***
// ramp level shared between the ramp generator and the sequencer
`timescale 1ns/100ps
`default_nettype none
interface ramp_if;
    import mute_seq_pkg::*;
    logic go_up;
    logic step;
    logic [RAMP_W-1:0] level;
    modport gen (input go_up, input step, output level);
    modport user (output go_up, output step, input level);
endinterface
`default_nettype wire

// *** ramp_gen.sv ***
// gain ramp pin voltage model, moved one step per enable
`timescale 1ns/100ps
`default_nettype none
module ramp_gen
    import mute_seq_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    ramp_if.gen rif
);
    logic [RAMP_W-1:0] level_r;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            level_r <= RAMP_RST;
        end else if (rif.step) begin
            if (rif.go_up && level_r != RAMP_FULL) begin
                level_r <= level_r + 10'h001;
            end else if (!rif.go_up && level_r != RAMP_RST) begin
                level_r <= level_r - 10'h001;
            end
        end
    end

    assign rif.level = level_r;
endmodule
`default_nettype wire

// *** fault_mute_seq.sv ***
// channel fault handling and mute/play sequencing top
`timescale 1ns/100ps
`default_nettype none
module fault_mute_seq
    import mute_seq_pkg::*;
#(
    parameter int OC_TIME_CYC = 200
)(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [1:0] mode_cmd,
    input wire logic mode_cmd_valid,
    input wire logic [NUM_CH-1:0] cycle_limit,
    input wire logic [NUM_CH-1:0] clip_det,
    input wire logic [NUM_CH-1:0] dc_fault,
    input wire logic [NUM_CH-1:0] diag_req,
    input wire logic [NUM_CH-1:0] load_open,
    input wire logic [NUM_CH-1:0] load_short,
    input wire logic [NUM_CH-1:0] fault_clear,
    input wire logic bridged_parallel,
    output logic [7:0] gain,
    output logic mute_entered,
    output logic play_entered,
    output logic [NUM_CH-1:0] outputs_floating_state,
    output logic [NUM_CH-1:0] overcurrent_trip,
    output logic [NUM_CH-1:0] dc_flag,
    output logic [NUM_CH-1:0] open_flag,
    output logic [NUM_CH-1:0] short_flag,
    output logic warn_indicator_n,
    output logic alert_n
);
    // refuse timer lengths the 16-bit counter cannot serve
    if (OC_TIME_CYC < 1 || OC_TIME_CYC > 65535) begin : g_bad_par
        $error("OC_TIME_CYC out of range");
    end

    ramp_if rif ();
    ramp_gen u_ramp (.ref_clk(ref_clk), .nrst(nrst), .rif(rif));

    // pin-side inputs pass two flops
    logic [NUM_CH-1:0] cl_s1, cl_s2, cp_s1, cp_s2, dc_s1, dc_s2;
    logic [NUM_CH-1:0] op_s1, op_s2, sh_s1, sh_s2;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cl_s1 <= '0; cl_s2 <= '0; cp_s1 <= '0; cp_s2 <= '0;
            dc_s1 <= '0; dc_s2 <= '0; op_s1 <= '0; op_s2 <= '0;
            sh_s1 <= '0; sh_s2 <= '0;
        end else begin
            cl_s1 <= cycle_limit; cl_s2 <= cl_s1;
            cp_s1 <= clip_det; cp_s2 <= cp_s1;
            dc_s1 <= dc_fault; dc_s2 <= dc_s1;
            op_s1 <= load_open; op_s2 <= op_s1;
            sh_s1 <= load_short; sh_s2 <= sh_s1;
        end
    end

    // step enable divider
    logic [7:0] div_r;
    logic step_r;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            div_r <= 8'h00;
            step_r <= 1'b0;
        end else if (div_r == 8'(STEP_CYC - 1)) begin
            div_r <= 8'h00;
            step_r <= 1'b1;
        end else begin
            div_r <= div_r + 8'h01;
            step_r <= 1'b0;
        end
    end

    // global mode target; ramp direction set by command
    logic play_tgt_r;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            play_tgt_r <= 1'b0;
        end else if (mode_cmd_valid) begin
            play_tgt_r <= (mode_cmd == MODE_PLAY);
        end
    end
    assign rif.go_up = play_tgt_r;
    assign rif.step = step_r;

    // gain map from ramp level: zero below 1/3, full above 2/3
    function automatic logic [7:0] gain_of(input logic [RAMP_W-1:0] lv);
        logic [RAMP_W-1:0] d;
        d = '0;
        if (lv <= LVL_THIRD) begin
            return 8'h00;
        end else if (lv >= LVL_TWO_THIRD) begin
            return GAIN_MAX;
        end
        // scale the third-wide span onto the full gain range, no jump at 2/3
        d = (lv - LVL_THIRD) * 10'h003;
        return d[9:2];
    endfunction

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            gain <= 8'h00;
        end else begin
            gain <= gain_of(rif.level);
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            mute_entered <= 1'b1;
            play_entered <= 1'b0;
        end else begin
            if (play_tgt_r) begin
                mute_entered <= 1'b0;
                if (rif.level >= LVL_NINE_TENTH) begin
                    play_entered <= 1'b1;
                end
            end else begin
                play_entered <= 1'b0;
                if (rif.level <= LVL_TENTH) begin
                    mute_entered <= 1'b1;
                end
            end
        end
    end

    // per-channel state, timers and latched flags
    ch_state_e st_r [NUM_CH];
    logic [15:0] oc_cnt_r [NUM_CH];
    logic [NUM_CH-1:0] active;
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            active[i] = (st_r[i] == ST_MUTE) || (st_r[i] == ST_PLAY);
        end
    end

    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        logic oc_hit;
        logic dc_hit;
        assign oc_hit = active[c] && cl_s2[c]
            && oc_cnt_r[c] == 16'(OC_TIME_CYC - 1);
        assign dc_hit = (st_r[c] == ST_PLAY) && dc_s2[c];

        always_ff @(posedge ref_clk or negedge nrst) begin
            if (!nrst) begin
                oc_cnt_r[c] <= 16'h0000;
            end else if (active[c] && cl_s2[c]) begin
                oc_cnt_r[c] <= oc_cnt_r[c] + 16'h0001;
            end else begin
                oc_cnt_r[c] <= 16'h0000;
            end
        end

        // hard mute into floating; diag only from floating
        always_ff @(posedge ref_clk or negedge nrst) begin
            if (!nrst) begin
                st_r[c] <= ST_FLOAT;
            end else if (oc_hit || dc_hit) begin
                st_r[c] <= ST_FLOAT;
            end else if (st_r[c] == ST_DIAG) begin
                st_r[c] <= ST_FLOAT;
            end else if (st_r[c] == ST_FLOAT && diag_req[c]) begin
                st_r[c] <= ST_DIAG;
            end else if (mode_cmd_valid
                    && !overcurrent_trip[c] && !dc_flag[c]) begin
                case (mode_cmd)
                    MODE_PLAY: st_r[c] <= ST_PLAY;
                    MODE_MUTE: st_r[c] <= ST_MUTE;
                    default: st_r[c] <= ST_FLOAT;
                endcase
            end
        end

        // latched flags, set wins over clear
        always_ff @(posedge ref_clk or negedge nrst) begin
            if (!nrst) begin
                overcurrent_trip[c] <= 1'b0;
                dc_flag[c] <= 1'b0;
            end else begin
                overcurrent_trip[c] <= oc_hit
                    || (overcurrent_trip[c] && !fault_clear[c]);
                dc_flag[c] <= dc_hit || (dc_flag[c] && !fault_clear[c]);
            end
        end

        always_ff @(posedge ref_clk or negedge nrst) begin
            if (!nrst) begin
                open_flag[c] <= 1'b0;
                short_flag[c] <= 1'b0;
            end else if (st_r[c] == ST_DIAG) begin
                open_flag[c] <= op_s2[c];
                short_flag[c] <= sh_s2[c];
            end
        end

        always_ff @(posedge ref_clk or negedge nrst) begin
            if (!nrst) begin
                outputs_floating_state[c] <= 1'b1;
            end else begin
                outputs_floating_state[c] <= !active[c] || oc_hit || dc_hit;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            warn_indicator_n <= 1'b1;
        end else begin
            warn_indicator_n <= !(|(active & cl_s2)
                || |(cp_s2 & {st_r[3] == ST_PLAY, st_r[2] == ST_PLAY,
                    st_r[1] == ST_PLAY, st_r[0] == ST_PLAY}));
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            alert_n <= 1'b1;
        end else begin
            alert_n <= !(|overcurrent_trip || |dc_flag);
        end
    end

    logic unused_par;
    assign unused_par = bridged_parallel;
endmodule
`default_nettype wire

// *** fault_mute_seq_checker.sv ***
// assertions on the sequencer top ports
`timescale 1ns/100ps
`default_nettype none
module fault_mute_seq_checker
    import mute_seq_pkg::*;
#(
    parameter int OC_TIME_CYC = 200
)(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [NUM_CH-1:0] cycle_limit,
    input wire logic [NUM_CH-1:0] clip_det,
    input wire logic [7:0] gain,
    input wire logic mute_entered,
    input wire logic play_entered,
    input wire logic [NUM_CH-1:0] outputs_floating_state,
    input wire logic [NUM_CH-1:0] overcurrent_trip,
    input wire logic [NUM_CH-1:0] open_flag,
    input wire logic warn_indicator_n,
    input wire logic alert_n
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    int lim_cnt;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            lim_cnt <= 0;
        end else begin
            lim_cnt <= (|cycle_limit) ? lim_cnt + 1 : 0;
        end
    end
    sequence limit_on;
        (|(cycle_limit & ~outputs_floating_state))[*3];
    endsequence
    sequence all_quiet;
        ((cycle_limit | clip_det) == '0)[*5];
    endsequence
    sequence trip_rise;
        |(overcurrent_trip & ~$past(overcurrent_trip));
    endsequence
    play_gain_full_a: assert property (
        play_entered |-> gain == GAIN_MAX
    ) else $error("play status while gain not full");
    mute_gain_zero_a: assert property (
        mute_entered |-> gain == 8'h00
    ) else $error("mute status while gain not zero");
    trip_floats_a: assert property (
        trip_rise |-> ##[0:1] (overcurrent_trip & ~outputs_floating_state) == '0
    ) else $error("tripped channel not floating");
    trip_alert_a: assert property (
        trip_rise |-> ##[0:1] !alert_n
    ) else $error("trip without alert");
    trip_time_a: assert property (
        trip_rise |-> lim_cnt >= OC_TIME_CYC
    ) else $error("trip before timer ran out");
    limit_warn_a: assert property (
        limit_on |-> ##[0:3] !warn_indicator_n
    ) else $error("current limit not shown");
    warn_clears_a: assert property (
        all_quiet |-> warn_indicator_n
    ) else $error("warning did not clear");
    diag_float_a: assert property (
        |(open_flag & ~$past(open_flag)) |-> (open_flag & ~$past(open_flag)
            & ~$past(outputs_floating_state, 2)) == '0
    ) else $error("diagnostic result outside floating state");
endmodule
bind fault_mute_seq fault_mute_seq_checker #(.OC_TIME_CYC(OC_TIME_CYC)) chk (
    .ref_clk(ref_clk), .nrst(nrst), .cycle_limit(cycle_limit),
    .clip_det(clip_det), .gain(gain), .mute_entered(mute_entered),
    .play_entered(play_entered), .open_flag(open_flag),
    .outputs_floating_state(outputs_floating_state),
    .overcurrent_trip(overcurrent_trip),
    .warn_indicator_n(warn_indicator_n), .alert_n(alert_n));
`default_nettype wire

// *** host_model.sv ***
// head unit model that issues mode commands
`timescale 1ns/100ps
`default_nettype none
module host_model (
    input wire logic ref_clk,
    output var logic [1:0] mode_cmd,
    output var logic mode_cmd_valid
);
    initial begin
        mode_cmd = 2'h3;
        mode_cmd_valid = 1'h0;
    end
    task automatic send(input logic [1:0] c);
        @(posedge ref_clk);
        #2;
        mode_cmd = c;
        mode_cmd_valid = 1'h1;
        @(posedge ref_clk);
        #2;
        mode_cmd = ~c;
        mode_cmd_valid = 1'h0;
    endtask
endmodule
`default_nettype wire

// *** tb_fault_mute_seq.sv ***
// self-checking bench for the fault and mute sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_fault_mute_seq
    import mute_seq_pkg::*;
;
    logic ref_clk, nrst, bridged_parallel, mode_cmd_valid;
    logic mute_entered, play_entered, warn_indicator_n, alert_n;
    logic [1:0] mode_cmd;
    logic [7:0] gain;
    logic [NUM_CH-1:0] cycle_limit, clip_det, dc_fault, diag_req, load_open;
    logic [NUM_CH-1:0] load_short, fault_clear, outputs_floating_state;
    logic [NUM_CH-1:0] overcurrent_trip, dc_flag, open_flag, short_flag;
    int errors = 0, cmp_count = 0, cyc = 0, i;
    host_model host (.ref_clk(ref_clk), .mode_cmd(mode_cmd),
        .mode_cmd_valid(mode_cmd_valid));
    fault_mute_seq #(.OC_TIME_CYC(4)) dut (.ref_clk(ref_clk), .nrst(nrst),
        .mode_cmd(mode_cmd), .mode_cmd_valid(mode_cmd_valid),
        .cycle_limit(cycle_limit), .clip_det(clip_det), .dc_fault(dc_fault),
        .diag_req(diag_req), .load_open(load_open), .load_short(load_short),
        .fault_clear(fault_clear), .bridged_parallel(bridged_parallel),
        .gain(gain), .mute_entered(mute_entered), .play_entered(play_entered),
        .outputs_floating_state(outputs_floating_state),
        .overcurrent_trip(overcurrent_trip), .dc_flag(dc_flag),
        .open_flag(open_flag), .short_flag(short_flag),
        .warn_indicator_n(warn_indicator_n), .alert_n(alert_n));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("FAIL t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask
    task automatic report_and_stop;
        $display("compares %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic t_diag;
        check({gain, mute_entered, play_entered}, 8'h02);
        load_open = 4'h5;
        load_short = 4'hA;
        diag_req = 4'hF;
        tick(6);
        diag_req = 4'h0;
        check(open_flag, 4'h5);
        check(short_flag, 4'hA);
    endtask
    task automatic t_play;
        host.send(MODE_PLAY);
        tick(6000);
        check(gain, 8'h00);
        for (i = 0; i < 20000 && play_entered !== 1'h1; i++) tick(1);
        check(i > 12300 && i < 12500, 1'h1);
        check({gain, mute_entered}, 9'h1FE);
    endtask
    task automatic t_play_faults;
        load_open = 4'hA;
        diag_req = 4'hF;
        clip_det = 4'h1;
        tick(6);
        diag_req = 4'h0;
        check(open_flag, 4'h5);
        check(warn_indicator_n, 1'h0);
        clip_det = 4'h0;
        dc_fault = 4'h4;
        tick(8);
        check({warn_indicator_n, alert_n}, 2'h2);
        check({dc_flag, outputs_floating_state}, 8'h44);
        dc_fault = 4'h0;
        fault_clear = 4'h4;
        tick(1);
        fault_clear = 4'h0;
        tick(3);
        check({dc_flag, alert_n}, 5'h01);
    endtask
    task automatic t_mute;
        host.send(MODE_MUTE);
        tick(1000);
        check(gain, GAIN_MAX);
        for (i = 0; i < 25000 && mute_entered !== 1'h1; i++) tick(1);
        check({gain, play_entered, mute_entered}, 10'h001);
    endtask
    task automatic t_overcurrent;
        cycle_limit = 4'h2;
        tick(3);
        check(warn_indicator_n, 1'h0);
        cycle_limit = 4'h0;
        tick(6);
        check({overcurrent_trip, warn_indicator_n}, 5'h01);
        cycle_limit = 4'h2;
        tick(12);
        check({overcurrent_trip, outputs_floating_state}, 8'h22);
        check({warn_indicator_n, alert_n}, 2'h2);
        cycle_limit = 4'h0;
        tick(8);
        check({overcurrent_trip, warn_indicator_n}, 5'h05);
        fault_clear = 4'h2;
        tick(1);
        fault_clear = 4'h0;
        tick(3);
        check({overcurrent_trip, alert_n}, 5'h01);
    endtask
    initial begin
        ref_clk = 1'h0;
        forever #25 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 60000) begin
            errors++;
            report_and_stop();
        end
    end
    initial begin
        nrst = 1'h0;
        bridged_parallel = 1'h1;
        {cycle_limit, clip_det, dc_fault, diag_req} = '0;
        {load_open, load_short, fault_clear} = '0;
        repeat (16) @(posedge ref_clk);
        #2;
        nrst = 1'h1;
        tick(2);
        t_diag();
        t_play();
        t_play_faults();
        t_mute();
        t_overcurrent();
        report_and_stop();
    end
endmodule
`default_nettype wire
